// *** design/reference_clock_divider.sv ***
// Reference clock divider top: APB registers, pin steering, checks
//
// Summary of operation
// - The system clock is the only source of the reference clock.
// - Divided clock feeds both the output pin and the modulator.
// - Generator runs only while the module enable bit is set.
// - Reference drives the pin only when the pin output enable is also set.
// - Three-bit divider select offers eight division options.
// - Two-bit duty select sets the output duty cycle.
// - Slew limiting applies while its bit is set, off when cleared.
// - Undivided clock keeps source duty except when 0% is chosen.
// - Divide by two: 25% and 75% accuracy follows source duty.
// - Any reset disables the module and restores control defaults.
// - No reference on the pin in any crystal oscillator mode.
// - No reference on the pin while instruction clock output is on.
// - With a pin conflict, module still runs and feeds the modulator.
// - Duty code 10 gives 50%, code 01 gives 25%.
// - Sleep stops the clock and holds outputs until wake.
// - Instruction clock output drives oscillator frequency over four.
`timescale 1ns/1ps
`default_nettype none
`include "refclk_defs.svh"

module reference_clock_divider (
    input  wire logic             clk,
    input  wire logic             rst_b,
    input  wire logic             ce,
    input  wire refclk_pkg::addr_t paddr,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [31:0]      pwdata,
    input  wire logic [3:0]       pstrb,
    output logic [31:0]           prdata,
    output logic                  pready,
    output logic                  pslverr,
    input  wire logic [2:0]       osc_mode_cfg,
    input  wire logic             instr_clock_output_cfg_enable,
    input  wire logic             sleep_active,
    output logic                  ref_clock_out_pin_o,
    output logic                  ref_clock_out_pin_oe,
    output logic                  ref_slew_limit_enable,
    output logic                  ref_mod_clk
);
    import refclk_pkg::*;

    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    typedef struct packed {
        ctrl_s       ctrl;
        logic [31:0] rdata;
        logic [1:0]  ic_cnt;
        logic        rd_ok;
    } top_s;

    top_s  st_q;
    top_s  st_d;
    logic  hit_ctrl;
    logic  hit_stat;
    logic  setup;
    logic  access;
    logic  crystal_mode;
    logic  pin_conflict;
    logic  wave;
    logic  ref_on_pin;
    logic  running;
    logic [31:0] stat_word;

    // ---------------------------------------------------------------
    // Divider and duty generator
    // ---------------------------------------------------------------
    // clocked only by the system clock
    ref_wave_gen u_wave (
        .clk          (clk),
        .rst_b        (rst_b),
        .ce           (ce),
        .enable       (st_q.ctrl.ref_module_enable),
        .sleep_active (sleep_active),
        .div_sel      (st_q.ctrl.ref_divider_select),
        .duty_sel     (st_q.ctrl.ref_duty_select),
        .wave         (wave)
    );

    // ---------------------------------------------------------------
    // Bus decode and pin conflict terms
    // ---------------------------------------------------------------
    assign hit_ctrl     = addr_hit(paddr, `RC_CTRL_OFF);
    assign hit_stat     = addr_hit(paddr, `RC_STAT_OFF);
    assign setup        = psel && !penable;
    assign access       = psel && penable && ce;
    // crystal modes claim the pin as an oscillator input
    assign crystal_mode = (osc_mode_cfg == `RC_OSC_LP) || (osc_mode_cfg == `RC_OSC_XT)
                        || (osc_mode_cfg == `RC_OSC_HS);
    assign pin_conflict = crystal_mode || instr_clock_output_cfg_enable;
    // generator runs only with the enable
    assign running      = st_q.ctrl.ref_module_enable && !sleep_active;
    // pin needs both enables and no conflict
    assign ref_on_pin   = st_q.ctrl.ref_module_enable && st_q.ctrl.ref_pin_output_enable
                        && !pin_conflict;

    // Status word with the block's live state
    always_comb begin
        stat_word                  = `RC_RDATA_ZERO;
        stat_word[`RC_ST_RUN]      = running;
        stat_word[`RC_ST_PIN_REF]  = ref_on_pin;
        stat_word[`RC_ST_CONFLICT] = pin_conflict;
        stat_word[`RC_ST_LEVEL]    = wave;
        stat_word[`RC_ST_IC_OUT]   = st_q.ic_cnt[`RC_IC_OUT_BIT];
    end

    // ---------------------------------------------------------------
    // Next state: register writes, read capture, instruction clock
    // ---------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        // Write takes effect at the completing access edge, lane 0 only
        if (access && pwrite && hit_ctrl && pstrb[`RC_STB_LANE0]) begin
            // divider, duty and control fields stored as written
            st_d.ctrl = ctrl_s'(pwdata[`RC_CTRL_MSB:`RC_CTRL_LSB]);
        end
        // Read data captured in setup; a setup hidden by a stall is caught
        // up in the access cycle, which then waits one cycle on pready
        if (psel && !pwrite && (setup || !st_q.rd_ok)) begin
            if (hit_ctrl) begin
                st_d.rdata = {24'h00_0000, st_q.ctrl};
            end else if (hit_stat) begin
                st_d.rdata = stat_word;
            end else begin
                st_d.rdata = `RC_RDATA_ZERO;
            end
            st_d.rd_ok = 1'b1;
        end else begin
            st_d.rd_ok = 1'b0;
        end
        // oscillator frequency over four, stopped in sleep
        if (instr_clock_output_cfg_enable && !sleep_active) begin
            st_d.ic_cnt = st_q.ic_cnt + `RC_IC_ONE;
        end else if (!instr_clock_output_cfg_enable) begin
            st_d.ic_cnt = `RC_IC_ZERO;
        end
    end

    // State register; clock enable freezes everything
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            // module disabled, control back to defaults
            st_q.ctrl   <= ctrl_s'(`RC_CTRL_RST);
            st_q.rdata  <= `RC_RDATA_ZERO;
            st_q.ic_cnt <= `RC_IC_ZERO;
            st_q.rd_ok  <= 1'b0;
        end else if (ce) begin
            st_q <= st_d;
        end
    end

    // ---------------------------------------------------------------
    // APB answer: no wait state unless ce is low or a stall hid the read setup
    // ---------------------------------------------------------------
    assign pready  = ce && (pwrite || st_q.rd_ok);
    assign pslverr = psel && penable && (!(hit_ctrl || hit_stat) || (pwrite && hit_stat));
    assign prdata  = st_q.rdata;

    // ---------------------------------------------------------------
    // Outputs to the pin and the modulator
    // ---------------------------------------------------------------
    // the same divided clock feeds the modulator
    // the modulator feed ignores pin conflicts
    assign ref_mod_clk = wave;

    // slew limit follows its control bit
    assign ref_slew_limit_enable = st_q.ctrl.ref_slew_limit_enable;

    // Pin steering: instruction clock first, then the reference
    always_comb begin
        // instruction clock output outranks the reference
        if (instr_clock_output_cfg_enable) begin
            ref_clock_out_pin_o  = st_q.ic_cnt[`RC_IC_OUT_BIT];
            ref_clock_out_pin_oe = 1'b1;
        end else if (ref_on_pin) begin
            ref_clock_out_pin_o  = wave;
            ref_clock_out_pin_oe = 1'b1;
        end else begin
            ref_clock_out_pin_o  = 1'b0;
            ref_clock_out_pin_oe = 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    sequence ctrl_write_s;
        psel && penable && pwrite && ce && hit_ctrl && pstrb[`RC_STB_LANE0];
    endsequence

    sequence div2_run_s;
        (ce && running && st_q.ctrl.ref_divider_select == `RC_DIV_TWO
         && st_q.ctrl.ref_duty_select == `RC_DUTY_50) [*3];
    endsequence

    sequence asleep_s;
        (sleep_active && !instr_clock_output_cfg_enable) [*2];
    endsequence

    // divider field takes the written code
    ctrl_write_a: assert property (@(posedge clk) disable iff (!rst_b)
        ctrl_write_s |=> st_q.ctrl.ref_divider_select == $past(pwdata[2:0]))
        else $error("divider select did not take the written value");

    // slew output tracks a written slew bit
    slew_follow_a: assert property (@(posedge clk) disable iff (!rst_b)
        ctrl_write_s |=> ref_slew_limit_enable == $past(pwdata[5]))
        else $error("slew limit output does not follow its bit");

    // crystal modes keep the pin undriven by the reference
    crystal_block_a: assert property (@(posedge clk) disable iff (!rst_b)
        (crystal_mode && !instr_clock_output_cfg_enable) |-> !ref_clock_out_pin_oe)
        else $error("pin driven while a crystal mode is selected");

    instr_prio_a: assert property (@(posedge clk) disable iff (!rst_b)
        instr_clock_output_cfg_enable |-> ref_clock_out_pin_oe
            && ref_clock_out_pin_o == st_q.ic_cnt[`RC_IC_OUT_BIT])
        else $error("instruction clock not on the pin");

    instr_div4_a: assert property (@(posedge clk) disable iff (!rst_b)
        (ce && instr_clock_output_cfg_enable && !sleep_active) [*5]
        |-> st_q.ic_cnt[`RC_IC_OUT_BIT] == $past(st_q.ic_cnt[`RC_IC_OUT_BIT], 4))
        else $error("instruction clock period is not four cycles");

    // without the pin enable the reference stays off the pin
    pin_gate_a: assert property (@(posedge clk) disable iff (!rst_b)
        (!st_q.ctrl.ref_pin_output_enable && !instr_clock_output_cfg_enable)
        |-> !ref_clock_out_pin_oe)
        else $error("pin driven without its output enable");

    // disabled module gives a low internal clock
    disabled_low_a: assert property (@(posedge clk) disable iff (!rst_b)
        !st_q.ctrl.ref_module_enable |-> !ref_mod_clk && !stat_word[`RC_ST_RUN])
        else $error("internal clock active while disabled");

    // divide by two at 50% toggles every cycle
    div2_toggle_a: assert property (@(posedge clk) disable iff (!rst_b)
        div2_run_s |-> ref_mod_clk != $past(ref_mod_clk))
        else $error("divide by two at half duty does not toggle");

    // conflicts leave the modulator feed running
    conflict_feed_a: assert property (@(posedge clk) disable iff (!rst_b)
        (pin_conflict and div2_run_s) |-> ref_mod_clk != $past(ref_mod_clk))
        else $error("modulator feed stopped by a pin conflict");

    sleep_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
        asleep_s |-> $stable(ref_mod_clk) && $stable(ref_clock_out_pin_o))
        else $error("outputs moved during sleep");

    // Unmapped addresses answer with an error
    unmapped_err_a: assert property (@(posedge clk) disable iff (!rst_b)
        (psel && penable && !hit_ctrl && !hit_stat)
        |-> pslverr && pready == (ce && (pwrite || st_q.rd_ok)))
        else $error("unmapped access not flagged");

    // Read answer waits while its data are not yet captured
    read_wait_a: assert property (@(posedge clk) disable iff (!rst_b)
        (psel && penable && !pwrite && !st_q.rd_ok) |-> !pready)
        else $error("read answered before its data were captured");

    // disabled module keeps the divider counter cleared
    count_clear_a: assert property (@(posedge clk) disable iff (!rst_b)
        (ce && !st_q.ctrl.ref_module_enable) |=> u_wave.st_q.cnt == `RC_CNT_ZERO)
        else $error("divider counter not cleared while disabled");

    // an allowed pin carries the modulator waveform
    pin_feed_a: assert property (@(posedge clk) disable iff (!rst_b)
        (ref_on_pin && !instr_clock_output_cfg_enable)
        |-> ref_clock_out_pin_oe && ref_clock_out_pin_o == ref_mod_clk)
        else $error("reference missing from an allowed pin");

endmodule : reference_clock_divider

`default_nettype wire

// *** design/refclk_defs.svh ***
// Constants for the reference clock divider: offsets, fields, resets, codes
`ifndef REFCLK_DEFS_SVH
`define REFCLK_DEFS_SVH

// ---------------------------------------------------------------
// Register map (byte addresses)
// ---------------------------------------------------------------
`define RC_CTRL_OFF      12'h000
`define RC_STAT_OFF      12'h004
`define RC_CTRL_RST      8'h30
`define RC_RDATA_ZERO    32'h0000_0000

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define RC_CTRL_LSB      0
`define RC_CTRL_MSB      7
`define RC_STB_LANE0     0
`define RC_ST_RUN        0
`define RC_ST_PIN_REF    1
`define RC_ST_CONFLICT   2
`define RC_ST_LEVEL      3
`define RC_ST_IC_OUT     4

// ---------------------------------------------------------------
// Divider and duty codes
// ---------------------------------------------------------------
`define RC_DIV_BASE      3'h0
`define RC_DIV_TWO       3'h1
`define RC_DUTY_0        2'h0
`define RC_DUTY_25       2'h1
`define RC_DUTY_50       2'h2
`define RC_DUTY_75       2'h3

// ---------------------------------------------------------------
// Oscillator mode codes and counter constants
// ---------------------------------------------------------------
`define RC_OSC_LP        3'h0
`define RC_OSC_XT        3'h1
`define RC_OSC_HS        3'h2
`define RC_CNT_ZERO      7'h00
`define RC_CNT_ONE       7'h01
`define RC_PERIOD_ONE    8'h01
`define RC_QUARTER_SHIFT 2
`define RC_IC_ZERO       2'h0
`define RC_IC_ONE        2'h1
`define RC_IC_OUT_BIT    1

`endif

// *** design/refclk_pkg.sv ***
// Types and helper functions shared by the reference clock divider files
`include "refclk_defs.svh"

package refclk_pkg;

    // ---------------------------------------------------------------
    // Control register layout, most significant field first
    // ---------------------------------------------------------------
    typedef struct packed {
        logic       ref_module_enable;
        logic       ref_pin_output_enable;
        logic       ref_slew_limit_enable;
        logic [1:0] ref_duty_select;
        logic [2:0] ref_divider_select;
    } ctrl_s;

    typedef logic [11:0] addr_t;

    // Counter wrap mask for a divide by two to the power of the code
    function automatic logic [6:0] period_mask(input logic [2:0] div);
        logic [7:0] period;
        period = `RC_PERIOD_ONE << div;
        return 7'(period - `RC_PERIOD_ONE);
    endfunction : period_mask

    // Exact decode of all address bits of an APB address against a register offset
    function automatic logic addr_hit(input addr_t addr, input addr_t off);
        return addr == off;
    endfunction : addr_hit

endpackage : refclk_pkg

// *** design/ref_wave_gen.sv ***
// Divider counter and duty shaper producing the internal reference clock
`timescale 1ns/1ps
`default_nettype none
`include "refclk_defs.svh"

module ref_wave_gen (
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic       ce,
    input  wire logic       enable,
    input  wire logic       sleep_active,
    input  wire logic [2:0] div_sel,
    input  wire logic [1:0] duty_sel,
    output logic            wave
);
    import refclk_pkg::*;

    typedef struct packed {
        logic [6:0] cnt;
        logic       level;
    } wave_s;

    wave_s      st_q;
    wave_s      st_d;
    logic       advance;
    logic [6:0] mask;
    logic [6:0] cnt_next;
    logic [7:0] quarter;
    logic [7:0] thresh;

    // ---------------------------------------------------------------
    // Next state: count through one period, level from phase vs duty
    // ---------------------------------------------------------------
    always_comb begin
        st_d     = st_q;
        advance  = ce && !sleep_active;
        mask     = period_mask(div_sel);
        cnt_next = (st_q.cnt + `RC_CNT_ONE) & mask;
        quarter  = ({1'b0, mask} + `RC_PERIOD_ONE) >> `RC_QUARTER_SHIFT;
        // duty code scales the high-time threshold
        thresh   = 8'(duty_sel * quarter);
        if (!enable) begin
            st_d.cnt   = `RC_CNT_ZERO;
            st_d.level = 1'b0;
        end else if (advance) begin
            st_d.cnt = cnt_next;
            // period two to the power of the code
            if (div_sel == `RC_DIV_BASE) begin
                st_d.level = duty_sel != `RC_DUTY_0;
            end else if (div_sel == `RC_DIV_TWO) begin
                st_d.level = (cnt_next == `RC_CNT_ZERO) && (duty_sel != `RC_DUTY_0);
            end else begin
                // high for duty quarters of the period
                st_d.level = {1'b0, cnt_next} < thresh;
            end
        end
    end

    // State register, frozen while the clock enable is low
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_q <= '0;
        end else if (ce) begin
            st_q <= st_d;
        end
    end

    // ---------------------------------------------------------------
    // Output shaping; half-cycle cases use the source clock itself
    // ---------------------------------------------------------------
    always_comb begin
        // held at the last level while asleep or frozen
        if (!enable || sleep_active || !ce) begin
            wave = st_q.level && enable;
        end else if (div_sel == `RC_DIV_BASE) begin
            // source duty passes unless 0% is chosen
            wave = (duty_sel != `RC_DUTY_0) && clk;
        end else if (div_sel == `RC_DIV_TWO && duty_sel == `RC_DUTY_25) begin
            // quarter duty rides on the source clock's high phase
            wave = st_q.level && clk;
        end else if (div_sel == `RC_DIV_TWO && duty_sel == `RC_DUTY_75) begin
            wave = st_q.level || clk;
        end else begin
            wave = st_q.level;
        end
    end

endmodule : ref_wave_gen

`default_nettype wire

// *** test/ref_load_model.sv ***
// Load model on the far side: counts reference levels, edges and pin highs
`timescale 1ns/1ps
`default_nettype none

module ref_load_model (
    input  wire logic clk,
    input  wire logic measure,
    input  wire logic mod_clk,
    input  wire logic pin_o,
    input  wire logic pin_oe,
    output var  int   high_cnt,
    output var  int   rise_cnt,
    output var  int   pin_cnt
);
    logic prev_s = 1'b0;
    logic meas_q = 1'b0;
    logic wire_s = 1'b0;

    // Sample one half cycle; a released pin shows the inverse of its last level
    task automatic take();
        if (measure && !meas_q) begin
            high_cnt = 0;
            rise_cnt = 0;
            pin_cnt = 0;
        end
        meas_q = measure;
        wire_s = (pin_oe === 1'b1) ? pin_o : ~wire_s;
        if (measure) begin
            high_cnt += (mod_clk === 1'b1);
            rise_cnt += (mod_clk === 1'b1 && !prev_s);
            pin_cnt += (pin_oe === 1'b1 && wire_s === 1'b1);
        end
        prev_s = (mod_clk === 1'b1);
    endtask : take

    // Look once in each half cycle, just after the edge, so gated outputs settle
    always begin
        @(posedge clk);
        #1;
        take();
        @(negedge clk);
        #1;
        take();
    end
endmodule : ref_load_model
`default_nettype wire

// *** test/tb.sv ***
// Self-checking testbench for the reference clock divider
`timescale 1ns/1ps
`default_nettype none
`include "refclk_defs.svh"

module tb;
    import refclk_pkg::*;
    logic clk = 1'b0, rst_b = 1'b0, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0] pstrb = 4'h0;
    logic pready, pslverr, pin_o, pin_oe, slew_o, mod_clk, er;
    logic [2:0] osc = 3'h4;
    logic instr = 1'b0, sleep = 1'b0, measure = 1'b0, ce_rand = 1'b0;
    logic [31:0] r;
    logic [7:0] cfg;
    logic [1:0] ic_ph = 2'h0, ic_snap = 2'h0;
    int high_cnt, rise_cnt, pin_cnt, err_total = 0, cmp_count = 0, cyc = 0, seed = 77358;

    reference_clock_divider DUT (.clk(clk), .rst_b(rst_b), .ce(ce), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .osc_mode_cfg(osc),
        .instr_clock_output_cfg_enable(instr), .sleep_active(sleep),
        .ref_clock_out_pin_o(pin_o), .ref_clock_out_pin_oe(pin_oe),
        .ref_slew_limit_enable(slew_o), .ref_mod_clk(mod_clk));
    ref_load_model load (.clk(clk), .measure(measure), .mod_clk(mod_clk), .pin_o(pin_o),
        .pin_oe(pin_oe), .high_cnt(high_cnt), .rise_cnt(rise_cnt), .pin_cnt(pin_cnt));

    // Clock, random stalls through ce, and the hang limit
    always #5 clk = ~clk;
    always @(posedge clk) begin
        ce <= ce_rand ? ($random(seed) % 3 != 0) : 1'b1;
        // Own clk/4 phase: counts while the config bit is on and awake
        if (ce) begin
            ic_ph <= !instr ? 2'h0 : sleep ? ic_ph : ic_ph + 2'h1;
        end
        cyc++;
        if (cyc == 60000) begin
            err_total++;
            give_verdict();
        end
    end

    // ---------------------------------------------------------------
    // Compare and report
    // ---------------------------------------------------------------
    task automatic chk_bit(input string nm, input logic e, input logic g);
        cmp_count++;
        if (g !== e) begin
            err_total++;
            $display("BAD %s exp %b got %b", nm, e, g);
        end
    endtask : chk_bit
    task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            err_total++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask : chk_word
    task automatic chk_cnt(input string nm, input int e, input int g);
        cmp_count++;
        if (g != e) begin
            err_total++;
            $display("BAD %s exp %0d got %0d", nm, e, g);
        end
    endtask : chk_cnt
    task automatic give_verdict();
        if (err_total == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : give_verdict

    // ---------------------------------------------------------------
    // APB master and measurement window
    // ---------------------------------------------------------------
    task automatic apb(input logic wr, input addr_t a, input logic [31:0] d,
                       input logic [3:0] s);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= wr;
        pwdata <= d;
        pstrb <= s;
        @(posedge clk);
        ic_snap = ic_ph;
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rd_chk(input addr_t a, input logic [31:0] m, input logic [31:0] e,
                          input logic ee);
        apb(1'b0, a, 32'h0, 4'h0);
        chk_word("rdata", e & m, rd & m);
        chk_bit("pslverr", ee, er);
    endtask : rd_chk
    task automatic run_window();
        repeat (140) @(posedge clk);
        measure <= 1'b1;
        repeat (128) @(posedge clk);
        measure <= 1'b0;
        @(posedge clk);
    endtask : run_window

    // ---------------------------------------------------------------
    // Expected values
    // ---------------------------------------------------------------
    function automatic int high_exp(input logic [2:0] dv, input logic [1:0] dt);
        if (dv == `RC_DIV_BASE) begin
            return (dt == `RC_DUTY_0) ? 0 : 128;
        end
        return 64 * dt;
    endfunction : high_exp
    function automatic logic oe_exp(input logic [7:0] c, input logic ic, input logic [2:0] o);
        return ic ? 1'b1 : (o <= `RC_OSC_HS) ? 1'b0 : c[7] & c[6];
    endfunction : oe_exp
    function automatic logic [31:0] st_exp(input logic [7:0] c, input logic ic,
                                           input logic [2:0] o, input logic sl);
        logic conf;
        conf = ic | (o <= `RC_OSC_HS);
        return {27'h0, ic & ic_snap[1], 1'b0, conf, c[7] & c[6] & !conf, c[7] & !sl};
    endfunction : st_exp

    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial begin
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        rd_chk(`RC_CTRL_OFF, 32'hffff_ffff, 32'h30, 1'b0);
        ce_rand <= 1'b1;
        for (int i = 0; i < 10; i++) begin
            r = $random(seed);
            apb(1'b1, `RC_CTRL_OFF, r, 4'h1);
            rd_chk(`RC_CTRL_OFF, 32'hffff_ffff, {24'h0, r[7:0]}, 1'b0);
            apb(1'b1, `RC_CTRL_OFF, ~r, 4'he);
            rd_chk(`RC_CTRL_OFF, 32'hffff_ffff, {24'h0, r[7:0]}, 1'b0);
        end
        apb(1'b1, `RC_STAT_OFF, 32'hff, 4'hf);
        chk_bit("stat_wr_err", 1'b1, er);
        rd_chk(12'h008, 32'hffff_ffff, 32'h0, 1'b1);
        ce_rand <= 1'b0;
        apb(1'b1, `RC_CTRL_OFF, 32'h0, 4'h1);
        for (int k = 0; k < 32; k++) begin
            r = $random(seed);
            // Corner: crystal conflict on divide by two at half duty
            osc <= (k == 17) ? 3'h1 : r[2:0];
            instr <= r[3] & r[4];
            cfg = {1'b1, 1'b0, r[6], k[4:3], k[2:0]};
            apb(1'b1, `RC_CTRL_OFF, {24'h0, cfg}, 4'h1);
            cfg[6] = r[5];
            apb(1'b1, `RC_CTRL_OFF, {24'h0, cfg}, 4'h1);
            run_window();
            chk_cnt("high", high_exp(cfg[2:0], cfg[4:3]), high_cnt);
            chk_cnt("rise", (cfg[4:3] == 0) ? 0 : 128 >> cfg[2:0], rise_cnt);
            chk_bit("pin_oe", oe_exp(cfg, instr, osc), pin_oe);
            chk_cnt("pin", !oe_exp(cfg, instr, osc) ? 0 : instr ? 128 : high_cnt, pin_cnt);
            chk_bit("slew", cfg[5], slew_o);
            rd_chk(`RC_STAT_OFF, 32'h17, st_exp(cfg, instr, osc, 1'b0), 1'b0);
            cfg[7] = 1'b0;
            apb(1'b1, `RC_CTRL_OFF, {24'h0, cfg}, 4'h1);
            run_window();
            chk_cnt("off_high", 0, high_cnt);
            chk_bit("off_oe", instr, pin_oe);
        end
        osc <= 3'h4;
        instr <= 1'b0;
        apb(1'b1, `RC_CTRL_OFF, 32'hd3, 4'h1);
        sleep <= 1'b1;
        run_window();
        chk_cnt("sleep_rise", 0, rise_cnt);
        rd_chk(`RC_STAT_OFF, 32'h17, st_exp(8'hd3, 1'b0, 3'h4, 1'b1), 1'b0);
        sleep <= 1'b0;
        run_window();
        chk_cnt("wake_rise", 16, rise_cnt);
        chk_cnt("wake_pin", 128, pin_cnt);
        rst_b <= 1'b0;
        repeat (3) @(posedge clk);
        chk_bit("rst_mod", 1'b0, mod_clk);
        chk_bit("rst_oe", 1'b0, pin_oe);
        rst_b <= 1'b1;
        rd_chk(`RC_CTRL_OFF, 32'hffff_ffff, 32'h30, 1'b0);
        give_verdict();
    end
endmodule : tb
`default_nettype wire
